// ==== rtl/gpp_port.sv ====
/*
  serial voice port on a bearer-slot link: one 8-bit word each way per frame,
  mu-law encoded transmit data, received word out with a strobe.
  assumes the controller drives link clock and frame sync, both sampled here
  by the 100 MHz system clock after two flip-flops.
*/
// How it works
// - transmit and receive words are 8 bits and share one chosen bearer slot per frame.
// - frame sync is read on a falling edge of the link clock.
// - in the first slot, sync rising with clock low drives the first bit at the next clock rise.
// - in the first slot, sync rising with clock high drives the first bit at once.
// - later bits change on rising edges of the link clock.
// - output is released on the second falling edge inside the last bit.
// - input bits are taken on rising edges of the link clock.
// - the sign bit is 0 for negative samples and coding is symmetric.
// - all seven magnitude bits are inverted on the line.
// - the word is sign, three chord bits and four step bits.
module gpp_port (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire gpp_pkg::gpp_link_in_s link_in,
  output gpp_pkg::gpp_link_out_s link_out,
  input wire gpp_pkg::gpp_slot_e slot_sel_in,
  input wire gpp_pkg::gpp_sample_s tx_sample_in,
  input wire logic tx_load_in,
  output logic [7:0] rx_word_out,
  output logic rx_valid_out,
  output logic frame_out
);
  typedef enum logic [1:0] {
    GPP_IDLE = 2'b00,
    GPP_WAIT = 2'b01,
    GPP_XFER = 2'b10
  } gpp_state_e;

  // two-flop synchronisers, one per link pin; the third flop only feeds edge detection
  logic [2:0] pins;
  logic [2:0] sync_q;
  logic [2:0] prev_q;
  logic link_data_clock;
  logic frame_sync_pulse;
  logic din;
  logic dcl_rise;
  logic dcl_fall;
  logic fsc_rise;

  assign pins = {link_in.clk, link_in.sync, link_in.din};

  for (genvar g = 0; g < 3; g++) begin : g_pin_sync
    logic meta;
    logic stable;
    logic last;
    logic next_meta;
    logic next_stable;
    logic next_last;

    always_comb begin
      next_meta = pins[g];
      next_stable = meta;
      next_last = stable;
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        meta <= 1'b0;
        stable <= 1'b0;
        last <= 1'b0;
      end else begin
        meta <= next_meta;
        stable <= next_stable;
        last <= next_last;
      end
    end

    assign sync_q[g] = stable;
    assign prev_q[g] = last;
  end

  assign link_data_clock = sync_q[2];
  assign frame_sync_pulse = sync_q[1];
  assign din = sync_q[0];
  assign dcl_rise = link_data_clock & ~prev_q[2];
  assign dcl_fall = ~link_data_clock & prev_q[2];
  assign fsc_rise = frame_sync_pulse & ~prev_q[1];

  logic [7:0] tx_code;
  gpp_mulaw_enc u_enc (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .load_in(tx_load_in),
    .sample_in(tx_sample_in),
    .code_out(tx_code)
  );

  gpp_state_e state;
  gpp_state_e next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [1:0] fall_cnt;
  logic [1:0] next_fall_cnt;
  logic [1:0] half_cnt;
  logic [1:0] next_half_cnt;
  logic [3:0] skip_cnt;
  logic [3:0] next_skip_cnt;
  logic [7:0] tx_sh;
  logic [7:0] next_tx_sh;
  logic [7:0] rx_sh;
  logic [7:0] next_rx_sh;
  logic [7:0] rx_word;
  logic [7:0] next_rx_word;
  logic rx_valid;
  logic next_rx_valid;
  logic dout;
  logic next_dout;
  logic oe;
  logic next_oe;
  logic frame;
  logic next_frame;
  logic fsc_armed;
  logic next_fsc_armed;
  logic [3:0] rx_cnt;
  logic [3:0] next_rx_cnt;
  logic rx_take;

  // each data bit spans two link clock periods in this timing mode
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_fall_cnt = fall_cnt;
    next_half_cnt = half_cnt;
    next_skip_cnt = skip_cnt;
    next_tx_sh = tx_sh;
    next_dout = dout;
    next_oe = oe;
    case (state)
      GPP_IDLE: begin
        next_oe = 1'b0;
        if (fsc_rise) begin
          next_bit_cnt = gpp_pkg::BIT_CNT_W0;
          next_half_cnt = 2'h0;
          next_fall_cnt = 2'h0;
          // second slot waits one full word of bit periods
          next_skip_cnt = (slot_sel_in == gpp_pkg::GPP_SLOT_SECOND) ?
            4'(gpp_pkg::SLOT_BITS) : 4'h0;
          next_tx_sh = tx_code;
          if (slot_sel_in == gpp_pkg::GPP_SLOT_SECOND) begin
            // a clock already high counts as the first rise of the wait
            next_half_cnt = link_data_clock ? 2'h1 : 2'h0;
            next_state = GPP_WAIT;
          end else if (link_data_clock) begin
            next_oe = 1'b1;
            next_dout = tx_code[gpp_pkg::SIGN_POS];
            next_tx_sh = {tx_code[6:0], 1'b0};
            next_half_cnt = 2'h1;
            next_state = GPP_XFER;
          end else begin
            next_state = GPP_XFER;
          end
        end
      end
      GPP_WAIT: begin
        if (dcl_rise) begin
          next_half_cnt = half_cnt + 2'h1;
          if (half_cnt == 2'h1) begin
            next_half_cnt = 2'h0;
            next_skip_cnt = skip_cnt - 4'h1;
          end
        end
        if (skip_cnt == 4'h0) begin
          next_state = GPP_XFER;
        end
      end
      GPP_XFER: begin
        if (dcl_rise) begin
          // output changes on the first rise of each bit period
          if (half_cnt == 2'h0 || half_cnt == 2'h2) begin
            next_oe = 1'b1;
            next_dout = tx_sh[gpp_pkg::SIGN_POS];
            next_tx_sh = {tx_sh[6:0], 1'b0};
            next_half_cnt = 2'h1;
            if (half_cnt == 2'h2) begin
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end else begin
            // the receive group takes the input on this rise
            next_half_cnt = 2'h2;
          end
        end
        // both falls of the last bit period are counted, the rise between keeps the count
        if (dcl_fall && bit_cnt == gpp_pkg::LAST_BIT && oe) begin
          next_fall_cnt = fall_cnt + 2'h1;
          if (fall_cnt == 2'h1) begin
            next_oe = 1'b0;
            next_state = GPP_IDLE;
          end
        end
      end
      default: begin
        next_state = GPP_IDLE;
        next_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= GPP_IDLE;
      bit_cnt <= gpp_pkg::BIT_CNT_W0;
      fall_cnt <= 2'h0;
      half_cnt <= 2'h0;
      skip_cnt <= 4'h0;
      tx_sh <= gpp_pkg::IDLE_WORD;
      dout <= 1'b1;
      oe <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      fall_cnt <= next_fall_cnt;
      half_cnt <= next_half_cnt;
      skip_cnt <= next_skip_cnt;
      tx_sh <= next_tx_sh;
      dout <= next_dout;
      oe <= next_oe;
    end
  end

  // receive shifter, fed on the second rise of each bit period
  assign rx_take = (state == GPP_XFER) && dcl_rise && (half_cnt == 2'h1);

  always_comb begin
    next_rx_sh = rx_sh;
    next_rx_cnt = rx_cnt;
    next_rx_word = rx_word;
    next_rx_valid = 1'b0;
    if (state == GPP_IDLE && fsc_rise) begin
      next_rx_cnt = gpp_pkg::BIT_CNT_W0;
    end
    if (rx_take) begin
      next_rx_sh = {rx_sh[6:0], din};
      next_rx_cnt = rx_cnt + 4'h1;
      // word and strobe leave together so the word is never seen half shifted
      if (rx_cnt == gpp_pkg::LAST_BIT) begin
        next_rx_word = {rx_sh[6:0], din};
        next_rx_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_sh <= 8'h00;
      rx_word <= gpp_pkg::IDLE_WORD;
      rx_valid <= 1'b0;
      rx_cnt <= gpp_pkg::BIT_CNT_W0;
    end else begin
      rx_sh <= next_rx_sh;
      rx_word <= next_rx_word;
      rx_valid <= next_rx_valid;
      rx_cnt <= next_rx_cnt;
    end
  end

  // frame start is confirmed when sync is seen high at a falling edge
  always_comb begin
    next_fsc_armed = fsc_armed;
    next_frame = 1'b0;
    if (dcl_fall && frame_sync_pulse && fsc_armed) begin
      next_fsc_armed = 1'b0;
      next_frame = 1'b1;
    end
    // a new sync rise wins over a confirm in the same cycle
    if (fsc_rise) begin
      next_fsc_armed = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fsc_armed <= 1'b0;
      frame <= 1'b0;
    end else begin
      fsc_armed <= next_fsc_armed;
      frame <= next_frame;
    end
  end

  assign link_out.dout = dout;
  assign link_out.dout_oe = oe;
  assign rx_word_out = rx_word;
  assign rx_valid_out = rx_valid;
  assign frame_out = frame;
endmodule

// ==== rtl/gpp_pkg.sv ====
/*
  package for the serial voice port: link slot choices, mu-law field layout,
  timing counts and the structs that carry samples and link pins.
  assumes a 100 MHz system clock that oversamples the link data clock.
*/
package gpp_pkg;
  localparam int unsigned CLK_FREQ_HZ = 100000000;
  localparam int unsigned FRAME_RATE_HZ = 8000;
  localparam int unsigned FRAME_CYCLES = CLK_FREQ_HZ / FRAME_RATE_HZ;
  localparam int unsigned WORD_BITS = 8;
  localparam int unsigned SLOT_BITS = 8;
  localparam logic [3:0] BIT_CNT_W0 = 4'h0;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // mu-law field layout, word bit 7 goes out first
  localparam int unsigned SIGN_POS = 7;
  localparam int unsigned CHORD_HI = 6;
  localparam int unsigned CHORD_LO = 4;
  localparam int unsigned STEP_HI = 3;
  localparam int unsigned STEP_LO = 0;
  localparam logic [12:0] MAG_MAX = 13'h1fdf;
  localparam logic [12:0] MAG_BIAS = 13'h0021;
  localparam logic [7:0] MAG_INV_MASK = 8'h7f;
  localparam logic [7:0] IDLE_WORD = 8'hff;
  localparam logic [3:0] POS_HI = 4'hc;

  typedef enum logic [0:0] {
    GPP_SLOT_FIRST = 1'b0,
    GPP_SLOT_SECOND = 1'b1
  } gpp_slot_e;

  typedef struct packed {
    logic clk;
    logic sync;
    logic din;
  } gpp_link_in_s;

  typedef struct packed {
    logic dout;
    logic dout_oe;
  } gpp_link_out_s;

  typedef struct packed {
    logic sign;
    logic [12:0] mag;
  } gpp_sample_s;
endpackage

// ==== rtl/gpp_mulaw_enc.sv ====
/*
  mu-law encoder: sign-magnitude sample in, registered 8-bit code out.
  assumes sample is stable for one cycle while load_in is high.
*/
module gpp_mulaw_enc (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic load_in,
  input wire gpp_pkg::gpp_sample_s sample_in,
  output logic [7:0] code_out
);
  logic [7:0] code;
  logic [7:0] next_code;
  logic [13:0] biased;
  logic [2:0] chord;
  logic [3:0] step;

  always_comb begin
    biased = {1'b0, sample_in.mag} + {1'b0, gpp_pkg::MAG_BIAS};
    // clip so the biased value stays below bit 13 and lands in the top step
    if (sample_in.mag >= gpp_pkg::MAG_MAX) begin
      biased = {1'b0, gpp_pkg::MAG_MAX} + {1'b0, gpp_pkg::MAG_BIAS} - 14'h0001;
    end
    chord = 3'h0;
    for (int i = 5; i <= 12; i++) begin
      if (biased[i]) begin
        chord = 3'(i - 5);
      end
    end
    // shift amount kept 4 bits wide so the top chord does not wrap to zero
    step = 4'(biased >> (4'(chord) + 4'h1));
    next_code = code;
    if (load_in) begin
      // sign 1 for positive, magnitude inverted, chords double step size
      next_code = {sample_in.sign, chord, step} ^ gpp_pkg::MAG_INV_MASK;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      code <= gpp_pkg::IDLE_WORD;
    end else begin
      code <= next_code;
    end
  end

  assign code_out = code;
endmodule

// ==== verification/gpp_port_chk.sv ====
/* pin checker for gpp_port.
   assumes link pins reach the port through two sync flops. */
module gpp_port_chk (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire gpp_pkg::gpp_link_in_s link_in,
  input wire gpp_pkg::gpp_link_out_s link_out,
  input wire gpp_pkg::gpp_slot_e slot_sel_in,
  input wire gpp_pkg::gpp_sample_s tx_sample_in,
  input wire logic tx_load_in,
  input wire logic [7:0] rx_word_out,
  input wire logic rx_valid_out,
  input wire logic frame_out
);
  logic [5:0] clk_h, next_clk_h;
  logic [7:0] oe_cnt, next_oe_cnt;
  logic rose_r, fell_r;
  always_comb begin
    next_clk_h = {clk_h[4:0], link_in.clk};
    next_oe_cnt = link_out.dout_oe ? oe_cnt + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_h <= 6'h00;
      oe_cnt <= 8'h00;
    end else begin
      clk_h <= next_clk_h;
      oe_cnt <= next_oe_cnt;
    end
  end
  // link edge seen 2 to 6 cycles ago
  assign rose_r = clk_h[1] && !clk_h[5];
  assign fell_r = !clk_h[1] && clk_h[5];
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  a_oe_on_rise: assert property ($rose(link_out.dout_oe) |-> clk_h[1])
    else $error("output enabled while link clock low");
  a_dout_on_rise: assert property ($changed(link_out.dout) && link_out.dout_oe
    && $past(link_out.dout_oe) |-> rose_r) else $error("data bit changed off a rise");
  a_oe_off_fall: assert property ($fell(link_out.dout_oe) |-> fell_r)
    else $error("output released off a fall");
  a_oe_slot_len: assert property ($fell(link_out.dout_oe) |-> oe_cnt >= 8'hb9
    && oe_cnt <= 8'hc8) else $error("drive time not one word");
  a_rx_on_rise: assert property (rx_valid_out |-> rose_r)
    else $error("receive strobe off a rise");
  a_valid_pulse: assert property (rx_valid_out |=> !rx_valid_out)
    else $error("receive strobe too long");
  a_word_holds: assert property ($changed(rx_word_out) |-> rx_valid_out)
    else $error("receive word changed without strobe");
  a_frame_on_fall: assert property (frame_out |-> fell_r ##1 !frame_out)
    else $error("frame pulse off a fall");
endmodule
bind gpp_port gpp_port_chk chk_u (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
  .link_in(link_in), .link_out(link_out), .slot_sel_in(slot_sel_in),
  .tx_sample_in(tx_sample_in), .tx_load_in(tx_load_in), .rx_word_out(rx_word_out),
  .rx_valid_out(rx_valid_out), .frame_out(frame_out));

// ==== verification/gpp_ctrl_model.sv ====
/* link controller model: makes link clock, frame sync and receive bits.
   assumes it is the only driver of the port's link inputs. */
module gpp_ctrl_model (
  output gpp_pkg::gpp_link_in_s link_out,
  input wire gpp_pkg::gpp_link_out_s link_in,
  output logic [7:0] seen_out,
  output logic [7:0] oe_bad_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_out = 3'h0;
    seen_out = 8'h00;
    oe_bad_out = 8'h00;
  end
  task automatic run_frame(input logic hi, input logic slot, input logic [7:0] word);
    int off;
    int r;
    off = slot ? 16 : 0;
    link_out.clk = hi;
    #20 link_out.sync = 1'b1;
    if (!hi) #20;
    // clock runs only inside the frame
    for (int i = 0; i < 34; i++) begin
      link_out.clk = 1'b1;
      #62.5 link_out.clk = 1'b0;
      r = i - off;
      if (r >= 0 && r < 16) begin
        if (r % 2 == 0) seen_out[7 - r / 2] = link_in.dout;
        if (link_in.dout_oe !== 1'b1) oe_bad_out++;
      end else if (link_in.dout_oe !== 1'b0) oe_bad_out++;
      #30 link_out.sync = 1'b0;
      r = i + 1 - off;
      // bit held around its sampling rise, toggles when not in slot
      link_out.din = (r >= 0 && r < 16) ? word[7 - r / 2] : ~link_out.din;
      #32.5;
    end
    #120710;
  endtask
endmodule

// ==== verification/gpp_port_test.sv ====
/* self-checking bench for gpp_port.
   assumes the controller model owns the link pins. */
module gpp_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic hi;
    logic slot;
    gpp_pkg::gpp_sample_s smp;
    logic [7:0] din;
    logic [7:0] code;
  } gpp_row_s;
  logic clk_sys, arst_n, tx_load, rx_valid, frame;
  gpp_pkg::gpp_link_in_s link_i;
  gpp_pkg::gpp_link_out_s link_o;
  gpp_pkg::gpp_slot_e slot_sel;
  gpp_pkg::gpp_sample_s tx_sample;
  logic [7:0] rx_word, got_word, seen, bad;
  int fail_count, compares, cycles, got_n, n0, frame_n, f0;
  gpp_row_s rows [6] = '{'{1'b0, 1'b0, '{1'b1, 13'h0000}, 8'ha5, 8'hff},
    '{1'b0, 1'b1, '{1'b1, 13'h1fde}, 8'h3c, 8'h80}, '{1'b1, 1'b0, '{1'b0, 13'h1fff}, 8'h81, 8'h00},
    '{1'b1, 1'b1, '{1'b1, 13'h005f}, 8'h7e, 8'hdf}, '{1'b0, 1'b0, '{1'b0, 13'h001e}, 8'hff, 8'h70},
    '{1'b0, 1'b1, '{1'b1, 13'h0fdf}, 8'h00, 8'h8f}};
  gpp_port dut_u (.clk_sys_in(clk_sys), .arst_n_in(arst_n), .link_in(link_i), .link_out(link_o),
    .slot_sel_in(slot_sel), .tx_sample_in(tx_sample), .tx_load_in(tx_load),
    .rx_word_out(rx_word), .rx_valid_out(rx_valid), .frame_out(frame));
  gpp_ctrl_model part_u (.link_out(link_i), .link_in(link_o), .seen_out(seen), .oe_bad_out(bad));
  task check(input string what, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task finish_test;
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (rx_valid === 1'b1) begin
      got_word = rx_word;
      got_n++;
    end
    if (frame === 1'b1) frame_n++;
    if (cycles == 110000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    arst_n = 1'b0;
    tx_load = 1'b0;
    tx_sample = 14'h0000;
    slot_sel = gpp_pkg::GPP_SLOT_FIRST;
    repeat (3) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (rows[k]) begin
      @(posedge clk_sys);
      #1 slot_sel = gpp_pkg::gpp_slot_e'(rows[k].slot);
      tx_sample = rows[k].smp;
      tx_load = 1'b1;
      @(posedge clk_sys);
      #1 tx_load = 1'b0;
      n0 = got_n;
      f0 = frame_n;
      part_u.run_frame(rows[k].hi, rows[k].slot, rows[k].din);
      check("tx code", seen, rows[k].code);
      check("rx word", got_word, rows[k].din);
      check("rx strobes", 8'(got_n - n0), 8'h01);
      check("frame pulses", 8'(frame_n - f0), 8'h01);
      check("oe outside slot", bad, 8'h00);
    end
    // reset in mid-frame, then a frame with no new sample
    slot_sel = gpp_pkg::GPP_SLOT_FIRST;
    fork
      part_u.run_frame(1'b0, 1'b0, 8'h5a);
      begin
        #1000 arst_n = 1'b0;
        #20 check("reset oe", {7'h00, link_o.dout_oe}, 8'h00);
        check("reset dout", {7'h00, link_o.dout}, 8'h01);
        check("reset strobes", {6'h00, rx_valid, frame}, 8'h00);
        check("reset rx word", rx_word, 8'hff);
        @(posedge clk_sys);
        #1 arst_n = 1'b1;
      end
    join
    part_u.run_frame(1'b0, 1'b0, 8'hc3);
    check("idle tx code", seen, 8'hff);
    check("rx after reset", got_word, 8'hc3);
    finish_test();
  end
endmodule
